// File: rtl/bdm_gpr_ram.sv
// General purpose byte storage shared by all four banks
`timescale 1ns/10ps
`default_nettype none
module bdm_gpr_ram
	import bdm_pkg::*;
(
	input wire logic clk,
	input wire logic we,
	input wire logic [bdm_pkg::RAM_AW-1:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [bdm_pkg::RAM_AW-1:0] raddr,
	output logic [7:0] rdata
);
	import bdm_pkg::*;

	// ------------------------------------------------------------
	// Storage array
	// ------------------------------------------------------------
	// No reset on purpose: contents live on like plain static RAM
	logic [7:0] mem [RAM_DEPTH];

	// Write port, one byte per clock
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Asynchronous read keeps the bus wait to a single cycle
	assign rdata = mem[raddr];

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_ram_write_lands: assert property (@(posedge clk)
		we |=> (mem[$past(waddr)] == $past(wdata)))
		else $error("byte write did not land in storage");

	// No write on the last edge and the same cell: the byte must hold
	a_ram_retains: assert property (@(posedge clk)
		(!we ##1 $stable(raddr)) |-> $stable(rdata))
		else $error("storage changed without a write");

endmodule // bdm_gpr_ram
`default_nettype wire

// File: rtl/bdm_map.sv
// Banked data memory and special function register map, AHB-Lite slave
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module bdm_map
	import bdm_pkg::*;
#(
	parameter bit HAS_EXTRA_PORTS = 1'b1
) (
	input wire logic REF_CLK,
	input wire logic RSTN,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	output logic [bdm_pkg::PC_W-1:0] PC_VALUE
);
	import bdm_pkg::*;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	bdm_state_t state_reg, state_next;
	logic [FA_W-1:0] addr_reg, addr_next;
	logic addr_ok_reg, addr_ok_next;
	logic [31:0] hrdata_reg, hrdata_next;
	logic [7:0] timer0_reg, timer0_next;
	logic [PC_W-1:0] pc_reg, pc_next;
	logic [7:0] status_reg, status_next;
	logic [7:0] pointer_reg, pointer_next;
	logic [7:0] port_a_data_reg, port_a_data_next;
	logic [7:0] port_b_data_reg, port_b_data_next;
	logic [7:0] port_c_data_reg, port_c_data_next;
	logic [7:0] port4_data_reg, port4_data_next;
	logic [7:0] port4_dir_reg, port4_dir_next;
	logic [7:0] port5_data_reg, port5_data_next;
	logic [7:0] port5_dir_reg, port5_dir_next;
	logic [PROGRAM_COUNTER_HIGH_LATCH_W-1:0] program_counter_high_latch_reg, program_counter_high_latch_next;
	logic [7:0] interrupt_control_reg, interrupt_control_next;
	logic [7:0] peripheral_irq_flags_reg, peripheral_irq_flags_next;
	logic take, wr_en, valid, gpr_hit, sfr_hit;
	logic [FA_W-1:0] eff_addr;
	logic [6:0] off;
	logic [1:0] bank;
	logic [7:0] sfr_byte, rd_byte, ram_rdata, wd;
	logic [8:0] ram_off;
	logic [RAM_AW-1:0] ram_idx;

	// ------------------------------------------------------------
	// Address decode of the access in its data phase
	// ------------------------------------------------------------
	// Indirect access swaps in the pointer; a pointer aimed back at
	// the indirect location itself finds nothing, so it reads zero
	always_comb begin
		eff_addr = addr_reg;
		if (addr_reg[6:0] == OFF_INDIRECT) begin
			eff_addr = {status_reg[IRP_BIT], pointer_reg};
		end
		off = eff_addr[6:0];
		bank = eff_addr[8:7];
		valid = addr_ok_reg && (off != OFF_INDIRECT);
		gpr_hit = valid && (off >= OFF_GPR_LO);
		ram_off = {2'b00, off} - {2'b00, OFF_GPR_LO};
		if ((off >= OFF_SHARED_LO) || (bank == BANK0)) begin
			ram_idx = ram_off;
		end else if (bank == BANK1) begin
			ram_idx = BANK1_BASE + ram_off;
		end else if (bank == BANK2) begin
			ram_idx = BANK2_BASE + ram_off;
		end else begin
			ram_idx = BANK3_BASE + ram_off;
		end
	end

	// Register read select; anything not matched stays a miss
	always_comb begin
		sfr_hit = 1'b0;
		sfr_byte = BYTE_ZERO;
		if (valid) begin
			case (off)
				OFF_TIMER0: begin
					sfr_hit = (bank == BANK0) || (bank == BANK2);
					sfr_byte = timer0_reg;
				end
				OFF_PCL: begin
					sfr_hit = 1'b1;
					sfr_byte = pc_reg[7:0];
				end
				OFF_STATUS: begin
					sfr_hit = 1'b1;
					sfr_byte = status_reg;
				end
				OFF_POINTER: begin
					sfr_hit = 1'b1;
					sfr_byte = pointer_reg;
				end
				OFF_PORT_A_DATA: begin
					sfr_hit = (bank == BANK0);
					sfr_byte = port_a_data_reg & PORT_A_DATA_MASK;
				end
				OFF_PORT_B_DATA: begin
					sfr_hit = (bank == BANK0) || (bank == BANK2);
					sfr_byte = port_b_data_reg;
				end
				OFF_PORT_C_DATA: begin
					sfr_hit = (bank == BANK0);
					sfr_byte = port_c_data_reg;
				end
				OFF_PORT4: begin
					sfr_hit = HAS_EXTRA_PORTS && (bank <= BANK1);
					sfr_byte = (bank == BANK0) ? port4_data_reg : port4_dir_reg;
				end
				OFF_PORT5: begin
					sfr_hit = HAS_EXTRA_PORTS && (bank <= BANK1);
					sfr_byte = (bank == BANK0) ? port5_data_reg : port5_dir_reg;
				end
				OFF_PROGRAM_COUNTER_HIGH_LATCH: begin
					sfr_hit = 1'b1;
					sfr_byte = {3'h0, program_counter_high_latch_reg};
				end
				OFF_INTERRUPT_CONTROL: begin
					sfr_hit = 1'b1;
					sfr_byte = interrupt_control_reg;
				end
				OFF_PERIPHERAL_IRQ_FLAGS: begin
					sfr_hit = (bank == BANK0);
					sfr_byte = peripheral_irq_flags_reg & PERIPHERAL_IRQ_FLAGS_MASK;
				end
				default: sfr_hit = 1'b0;
			endcase
		end
		if (gpr_hit) begin
			rd_byte = ram_rdata;
		end else if (sfr_hit) begin
			rd_byte = sfr_byte;
		end else begin
			rd_byte = BYTE_ZERO;
		end
	end

	// ------------------------------------------------------------
	// Bus handshake
	// ------------------------------------------------------------
	// Reads take one wait state so that read data come from a flop
	assign take = HSEL && HTRANS[1] && HREADY;
	assign wr_en = (state_reg == ST_WRITE);
	assign HREADYOUT = (state_reg != ST_RWAIT);
	assign HRESP = HRESP_OKAY;
	assign HRDATA = hrdata_reg;
	assign PC_VALUE = pc_reg;

	always_comb begin
		state_next = state_reg;
		addr_next = addr_reg;
		addr_ok_next = addr_ok_reg;
		hrdata_next = hrdata_reg;
		case (state_reg)
			ST_RWAIT: begin
				hrdata_next = {RDATA_PAD, rd_byte};
				state_next = ST_RDONE;
			end
			ST_IDLE, ST_WRITE, ST_RDONE: begin
				state_next = ST_IDLE;
				if (take) begin
					addr_next = HADDR[HADDR_FA_MSB:HADDR_FA_LSB];
					addr_ok_next = (HADDR[31:HADDR_HI_LSB] == HADDR_HI_ZERO);
					state_next = HWRITE ? ST_WRITE : ST_RWAIT;
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			state_reg <= ST_IDLE;
			addr_reg <= '0;
			addr_ok_reg <= 1'b0;
			hrdata_reg <= '0;
		end else begin
			state_reg <= state_next;
			addr_reg <= addr_next;
			addr_ok_reg <= addr_ok_next;
			hrdata_reg <= hrdata_next;
		end
	end

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	// A miss writes nothing, so stray stores cannot disturb anything
	assign wd = HWDATA[7:0];

	always_comb begin
		timer0_next = timer0_reg;
		pc_next = pc_reg;
		status_next = status_reg;
		pointer_next = pointer_reg;
		port_a_data_next = port_a_data_reg;
		port_b_data_next = port_b_data_reg;
		port_c_data_next = port_c_data_reg;
		port4_data_next = port4_data_reg;
		port4_dir_next = port4_dir_reg;
		port5_data_next = port5_data_reg;
		port5_dir_next = port5_dir_reg;
		program_counter_high_latch_next = program_counter_high_latch_reg;
		interrupt_control_next = interrupt_control_reg;
		peripheral_irq_flags_next = peripheral_irq_flags_reg;
		if (wr_en && sfr_hit) begin
			case (off)
				OFF_TIMER0: timer0_next = wd;
				OFF_PCL: pc_next = {program_counter_high_latch_reg, wd};
				OFF_STATUS: status_next = (status_reg & ~STATUS_RW_MASK) |
					(wd & STATUS_RW_MASK);
				OFF_POINTER: pointer_next = wd;
				OFF_PORT_A_DATA: port_a_data_next = wd & PORT_A_DATA_MASK;
				OFF_PORT_B_DATA: port_b_data_next = wd;
				OFF_PORT_C_DATA: port_c_data_next = wd;
				OFF_PORT4: begin
					if (bank == BANK0) port4_data_next = wd;
					else port4_dir_next = wd;
				end
				OFF_PORT5: begin
					if (bank == BANK0) port5_data_next = wd;
					else port5_dir_next = wd;
				end
				OFF_PROGRAM_COUNTER_HIGH_LATCH: program_counter_high_latch_next = wd[PROGRAM_COUNTER_HIGH_LATCH_W-1:0];
				OFF_INTERRUPT_CONTROL: interrupt_control_next = wd;
				OFF_PERIPHERAL_IRQ_FLAGS: peripheral_irq_flags_next = wd & PERIPHERAL_IRQ_FLAGS_MASK;
				default: peripheral_irq_flags_next = peripheral_irq_flags_reg;
			endcase
		end
	end

	// Flops run on every edge; no clock gating, so contents hold
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			timer0_reg <= BYTE_ZERO;
			pc_reg <= PC_RESET;
			status_reg <= STATUS_RESET;
			pointer_reg <= BYTE_ZERO;
			port_a_data_reg <= BYTE_ZERO;
			port_b_data_reg <= BYTE_ZERO;
			port_c_data_reg <= BYTE_ZERO;
			port4_data_reg <= BYTE_ZERO;
			port4_dir_reg <= BYTE_ZERO;
			port5_data_reg <= BYTE_ZERO;
			port5_dir_reg <= BYTE_ZERO;
			program_counter_high_latch_reg <= PROGRAM_COUNTER_HIGH_LATCH_RESET;
			interrupt_control_reg <= BYTE_ZERO;
			peripheral_irq_flags_reg <= BYTE_ZERO;
		end else begin
			timer0_reg <= timer0_next;
			pc_reg <= pc_next;
			status_reg <= status_next;
			pointer_reg <= pointer_next;
			port_a_data_reg <= port_a_data_next;
			port_b_data_reg <= port_b_data_next;
			port_c_data_reg <= port_c_data_next;
			port4_data_reg <= port4_data_next;
			port4_dir_reg <= port4_dir_next;
			port5_data_reg <= port5_data_next;
			port5_dir_reg <= port5_dir_next;
			program_counter_high_latch_reg <= program_counter_high_latch_next;
			interrupt_control_reg <= interrupt_control_next;
			peripheral_irq_flags_reg <= peripheral_irq_flags_next;
		end
	end

	// Shared storage for every bank
	bdm_gpr_ram u_gpr (
		.clk(REF_CLK),
		.we(wr_en && gpr_hit),
		.waddr(ram_idx),
		.wdata(wd),
		.raddr(ram_idx),
		.rdata(ram_rdata)
	);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RSTN);

	a_unimpl_read_zero: assert property (
		(state_reg == ST_RWAIT && !gpr_hit && !sfr_hit) |=> HRDATA == 32'h0)
		else $error("unimplemented location did not read zero");
	a_shared_alias: assert property (
		(gpr_hit && off >= OFF_SHARED_LO) |->
		ram_idx == ({2'b00, off} - {2'b00, OFF_GPR_LO}))
		else $error("shared region not mapped onto bank zero");
	a_indirect_redirect: assert property (
		(state_reg == ST_RWAIT && addr_reg[6:0] == OFF_INDIRECT) |->
		eff_addr == {status_reg[IRP_BIT], pointer_reg})
		else $error("indirect access not redirected");
	a_no_extra_ports: assert property (
		(state_reg == ST_RWAIT && !HAS_EXTRA_PORTS &&
		(off == OFF_PORT4 || off == OFF_PORT5)) |=> HRDATA == 32'h0)
		else $error("absent port location read nonzero");
	a_pc_transfer: assert property (
		(wr_en && sfr_hit && off == OFF_PCL) |=>
		PC_VALUE == {$past(program_counter_high_latch_reg), $past(HWDATA[7:0])})
		else $error("counter not loaded from latch and low byte");
	a_unimpl_write_drop: assert property (
		(wr_en && !gpr_hit && !sfr_hit) |=> ($stable(status_reg) &&
		$stable(pointer_reg) && $stable(pc_reg) && $stable(program_counter_high_latch_reg)))
		else $error("discarded write changed a register");
	a_read_one_wait: assert property (
		(state_reg == ST_RWAIT) |-> !HREADYOUT ##1 HREADYOUT)
		else $error("read wait not exactly one cycle");

	c_shared_read: cover property (
		state_reg == ST_RWAIT && gpr_hit && off >= OFF_SHARED_LO);
	c_indirect_write: cover property (
		wr_en && addr_reg[6:0] == OFF_INDIRECT && gpr_hit);
	c_pc_load: cover property (wr_en && sfr_hit && off == OFF_PCL);

endmodule // bdm_map
`default_nettype wire

// File: rtl/bdm_pkg.sv
// Constants and types shared by the banked data memory map
`default_nettype none
package bdm_pkg;

	// ------------------------------------------------------------
	// Bus side layout
	// ------------------------------------------------------------
	localparam int FA_W = 9;
	localparam int HADDR_FA_LSB = 2;
	localparam int HADDR_FA_MSB = 10;
	localparam int HADDR_HI_LSB = 11;
	localparam logic [20:0] HADDR_HI_ZERO = 21'h000000;
	localparam logic HRESP_OKAY = 1'b0;
	localparam logic [23:0] RDATA_PAD = 24'h000000;

	// ------------------------------------------------------------
	// In-bank offsets of the special function registers
	// ------------------------------------------------------------
	localparam logic [6:0] OFF_INDIRECT = 7'h00;
	localparam logic [6:0] OFF_TIMER0 = 7'h01;
	localparam logic [6:0] OFF_PCL = 7'h02;
	localparam logic [6:0] OFF_STATUS = 7'h03;
	localparam logic [6:0] OFF_POINTER = 7'h04;
	localparam logic [6:0] OFF_PORT_A_DATA = 7'h05;
	localparam logic [6:0] OFF_PORT_B_DATA = 7'h06;
	localparam logic [6:0] OFF_PORT_C_DATA = 7'h07;
	localparam logic [6:0] OFF_PORT4 = 7'h08;
	localparam logic [6:0] OFF_PORT5 = 7'h09;
	localparam logic [6:0] OFF_PROGRAM_COUNTER_HIGH_LATCH = 7'h0A;
	localparam logic [6:0] OFF_INTERRUPT_CONTROL = 7'h0B;
	localparam logic [6:0] OFF_PERIPHERAL_IRQ_FLAGS = 7'h0C;
	localparam logic [6:0] OFF_GPR_LO = 7'h20;
	localparam logic [6:0] OFF_SHARED_LO = 7'h70;

	localparam logic [1:0] BANK0 = 2'h0;
	localparam logic [1:0] BANK1 = 2'h1;
	localparam logic [1:0] BANK2 = 2'h2;
	localparam logic [1:0] BANK3 = 2'h3;

	// ------------------------------------------------------------
	// General purpose storage
	// ------------------------------------------------------------
	localparam int RAM_AW = 9;
	localparam int RAM_DEPTH = 336;
	localparam logic [8:0] BANK1_BASE = 9'h060;
	localparam logic [8:0] BANK2_BASE = 9'h0B0;
	localparam logic [8:0] BANK3_BASE = 9'h100;

	// ------------------------------------------------------------
	// Field masks and reset values
	// ------------------------------------------------------------
	localparam int IRP_BIT = 7;
	localparam int PC_W = 13;
	localparam int PROGRAM_COUNTER_HIGH_LATCH_W = 5;
	localparam logic [7:0] PORT_A_DATA_MASK = 8'h3F;
	localparam logic [7:0] PERIPHERAL_IRQ_FLAGS_MASK = 8'h4F;
	localparam logic [7:0] STATUS_RW_MASK = 8'hE7;
	localparam logic [7:0] STATUS_RESET = 8'h18;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [4:0] PROGRAM_COUNTER_HIGH_LATCH_RESET = 5'h00;
	localparam logic [12:0] PC_RESET = 13'h0000;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WRITE,
		ST_RWAIT,
		ST_RDONE
	} bdm_state_t;

endpackage
`default_nettype wire

// File: sim/bdm_map_tb.sv
// Self-checking testbench for the banked data memory map
`timescale 1ns/10ps
`default_nettype none
module bdm_map_tb;

	// ------------------------------------------------------------
	// Stimulus table: write rows carry data, read rows the expectation
	// ------------------------------------------------------------
	typedef struct packed {
		logic wr;
		logic [8:0] fa;
		logic [7:0] d;
	} bdm_row_t;

	localparam bdm_row_t ROWS [63] = '{
	'{1'h1, 9'h001, 8'hC3}, '{1'h0, 9'h101, 8'hC3}, '{1'h0, 9'h081, 8'h00},
	'{1'h1, 9'h006, 8'hA5}, '{1'h0, 9'h106, 8'hA5}, '{1'h0, 9'h186, 8'h00},
	'{1'h1, 9'h007, 8'h3C}, '{1'h0, 9'h007, 8'h3C}, '{1'h0, 9'h107, 8'h00},
	'{1'h1, 9'h08B, 8'h81}, '{1'h0, 9'h18B, 8'h81}, '{1'h0, 9'h00B, 8'h81},
	'{1'h0, 9'h003, 8'h18}, '{1'h0, 9'h00A, 8'h00}, '{1'h0, 9'h002, 8'h00},
	'{1'h0, 9'h00C, 8'h00}, '{1'h0, 9'h000, 8'h00}, '{1'h1, 9'h1F0, 8'h5A},
	'{1'h0, 9'h070, 8'h5A}, '{1'h0, 9'h0F0, 8'h5A}, '{1'h0, 9'h170, 8'h5A},
	'{1'h1, 9'h020, 8'h11}, '{1'h1, 9'h0A0, 8'h22}, '{1'h1, 9'h120, 8'h33},
	'{1'h1, 9'h1A0, 8'h44}, '{1'h1, 9'h06F, 8'h55}, '{1'h1, 9'h0EF, 8'h66},
	'{1'h1, 9'h16F, 8'h77}, '{1'h1, 9'h1EF, 8'h88}, '{1'h0, 9'h020, 8'h11},
	'{1'h0, 9'h0A0, 8'h22}, '{1'h0, 9'h120, 8'h33}, '{1'h0, 9'h1A0, 8'h44},
	'{1'h0, 9'h06F, 8'h55}, '{1'h0, 9'h0EF, 8'h66}, '{1'h0, 9'h16F, 8'h77},
	'{1'h0, 9'h1EF, 8'h88}, '{1'h1, 9'h005, 8'hFF}, '{1'h0, 9'h005, 8'h3F},
	'{1'h1, 9'h00C, 8'hFF}, '{1'h0, 9'h00C, 8'h4F}, '{1'h1, 9'h003, 8'h00},
	'{1'h0, 9'h003, 8'h18}, '{1'h1, 9'h00D, 8'hFF}, '{1'h0, 9'h00D, 8'h00},
	'{1'h0, 9'h00C, 8'h4F}, '{1'h0, 9'h003, 8'h18}, '{1'h0, 9'h018, 8'h00},
	'{1'h0, 9'h08E, 8'h00}, '{1'h0, 9'h105, 8'h00}, '{1'h1, 9'h004, 8'h20},
	'{1'h1, 9'h000, 8'h99}, '{1'h0, 9'h020, 8'h99}, '{1'h0, 9'h080, 8'h99},
	'{1'h1, 9'h003, 8'h80}, '{1'h0, 9'h003, 8'h98}, '{1'h0, 9'h000, 8'h33},
	'{1'h1, 9'h003, 8'h00}, '{1'h1, 9'h004, 8'h80}, '{1'h0, 9'h000, 8'h00},
	'{1'h1, 9'h00A, 8'hFF}, '{1'h0, 9'h00A, 8'h1F}, '{1'h0, 9'h08A, 8'h1F}
	};
	localparam logic [8:0] XPORTS [4] = '{9'h008, 9'h009, 9'h088, 9'h089};

	logic ref_clk, rstn, hsel, hwrite;
	logic [31:0] haddr, hwdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [7:0] rd, rd2;
	wire logic [31:0] hrdata, hrdata2;
	wire logic hreadyout, hreadyout2, hresp, hresp2;
	wire logic [12:0] pc_value, pc_value2;
	int fail_count, tests_run, cycles;

	// Clock of 40 ns period
	always #20 ref_clk = ~ref_clk;

	// ------------------------------------------------------------
	// Full build and a build without the extra ports, on one bus
	// ------------------------------------------------------------
	bdm_map #(.HAS_EXTRA_PORTS(1'b1)) dut (.REF_CLK(ref_clk), .RSTN(rstn),
		.HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
		.HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
		.HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
		.PC_VALUE(pc_value));
	bdm_map #(.HAS_EXTRA_PORTS(1'b0)) dut_lean (.REF_CLK(ref_clk),
		.RSTN(rstn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
		.HREADY(hreadyout2), .HRDATA(hrdata2), .HREADYOUT(hreadyout2),
		.HRESP(hresp2), .PC_VALUE(pc_value2));

	// ------------------------------------------------------------
	// Compare tasks and closing report
	// ------------------------------------------------------------
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t byte got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t bus flag got %b expected %b", $time, got, exp);
		end
	endtask

	task automatic chk_pc(input logic [12:0] got, input logic [12:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t counter got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic conclude();
		$display("Comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// One single transfer; ready is looked at on the falling edge, where
	// it already shows what the next rising edge will sample
	task automatic bus(input logic wr, input logic [8:0] fa,
		input logic [7:0] wd, output logic [7:0] r1, output logic [7:0] r2);
		@(posedge ref_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {21'h000000, fa, 2'h0};
		@(negedge ref_clk);
		while (hreadyout !== 1'b1) @(negedge ref_clk);
		@(posedge ref_clk);
		htrans <= 2'h0;
		hwdata <= {24'h000000, wd};
		@(negedge ref_clk);
		while (hreadyout !== 1'b1) @(negedge ref_clk);
		r1 = hrdata[7:0];
		r2 = hrdata2[7:0];
		chk_bit(hresp || hresp2, 1'b0);
		chk_bit((|hrdata[31:8]) || (|hrdata2[31:8]), 1'b0);
		@(posedge ref_clk);
	endtask

	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fail_count++;
			$display("BAD %0t run did not finish", $time);
			conclude();
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		rstn = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		haddr = 32'h00000000;
		hwdata = 32'h00000000;
		htrans = 2'h0;
		hsize = 3'h2;
		fail_count = 0;
		tests_run = 0;
		cycles = 0;
		repeat (10) @(posedge ref_clk);
		rstn <= 1'b1;
		chk_pc(pc_value, 13'h0000);
		foreach (ROWS[i]) begin
			bus(ROWS[i].wr, ROWS[i].fa, ROWS[i].d, rd, rd2);
			if (!ROWS[i].wr) chk_byte(rd, ROWS[i].d);
			if (!ROWS[i].wr) chk_byte(rd2, ROWS[i].d);
		end
		// Low byte write moves the latched upper bits into the counter
		bus(1'b1, 9'h002, 8'h34, rd, rd2);
		@(negedge ref_clk);
		chk_pc(pc_value, 13'h1F34);
		chk_pc(pc_value2, 13'h1F34);
		bus(1'b0, 9'h002, 8'h00, rd, rd2);
		chk_byte(rd, 8'h34);
		// Extra port locations hold data only in the full build
		foreach (XPORTS[i])
			bus(1'b1, XPORTS[i], 8'hA0 + 8'(i), rd, rd2);
		foreach (XPORTS[i]) begin
			bus(1'b0, XPORTS[i], 8'h00, rd, rd2);
			chk_byte(rd, 8'hA0 + 8'(i));
			chk_byte(rd2, 8'h00);
		end
		// Second reset in mid-run: registers return, storage is kept
		@(posedge ref_clk);
		rstn <= 1'b0;
		@(negedge ref_clk);
		chk_pc(pc_value, 13'h0000);
		chk_pc(pc_value2, 13'h0000);
		repeat (2) @(posedge ref_clk);
		rstn <= 1'b1;
		bus(1'b0, 9'h003, 8'h00, rd, rd2);
		chk_byte(rd, 8'h18);
		bus(1'b0, 9'h00A, 8'h00, rd, rd2);
		chk_byte(rd, 8'h00);
		bus(1'b0, 9'h0F0, 8'h00, rd, rd2);
		chk_byte(rd, 8'h5A);
		chk_byte(rd2, 8'h5A);
		conclude();
	end

endmodule // bdm_map_tb
`default_nettype wire
